// File: common/lane_cfg_pkg.sv
// Purpose: Shared constants, types and carriers for the lane two B-path configuration bank
// Assumes: Management bus pins sampled on the core clock
// Notes: One byte-wide register per offset; offsets are management-bus register addresses
package lane_cfg_pkg;

  // Register offsets on the management bus
  localparam logic [7:0] IDLE_RATE_OFS = 8'h1C;
  localparam logic [7:0] BOOST_OFS = 8'h1D;
  localparam logic [7:0] SWING_OFS = 8'h1E;
  localparam logic [7:0] EMPH_OFS = 8'h1F;
  localparam logic [7:0] THRESH_OFS = 8'h20;
  localparam int NUM_REGS = 5;
  localparam logic [7:0] BANK_BASE = IDLE_RATE_OFS;

  // Reset values
  localparam logic [7:0] IDLE_RATE_RST = 8'h00;
  localparam logic [7:0] BOOST_RST = 8'h20;
  localparam logic [7:0] SWING_RST = 8'h03;
  localparam logic [7:0] EMPH_RST = 8'h03;
  localparam logic [7:0] THRESH_RST = 8'h00;

  // Field positions
  localparam int IDLE_AUTO_BIT = 5;
  localparam int IDLE_MAN_BIT = 4;
  localparam int RATE_AUTO_BIT = 1;
  localparam int RATE_MAN_BIT = 0;
  localparam int EQ_EN_BIT = 5;
  localparam int GAIN_HI = 4;
  localparam int GAIN_LO = 3;
  localparam int BOOST_HI = 2;
  localparam int BOOST_LO = 0;
  localparam int SWING_HI = 6;
  localparam int EMPH_TYPE_BIT = 7;
  localparam int EMPH_LVL_HI = 6;
  localparam int DEASSERT_HI = 3;
  localparam int DEASSERT_LO = 2;
  localparam int ASSERT_HI = 1;
  localparam int ASSERT_LO = 0;

  // Equalizer levels: three stages of eight boosts, and the nine strap codes
  localparam int EQ_BOOSTS = 8;
  localparam int EQ_STAGES = 3;
  localparam int EQ_STRAP_CODES = 9;
  localparam logic [EQ_STRAP_CODES-1:0][5:0] EQ_STRAP_TABLE = {
    6'h3D, 6'h3B, 6'h37, 6'h35, 6'h39, 6'h32, 6'h30, 6'h2A, 6'h20};

  // Output swing codes and levels in mV
  localparam logic [6:0] SWING_600 = 7'h03;
  localparam logic [6:0] SWING_800 = 7'h07;
  localparam logic [6:0] SWING_1000 = 7'h0F;
  localparam logic [6:0] SWING_1200 = 7'h1F;
  localparam logic [6:0] SWING_1400 = 7'h3F;
  localparam logic [10:0] MV_600 = 11'h258;
  localparam logic [10:0] MV_800 = 11'h320;
  localparam logic [10:0] MV_1000 = 11'h3E8;
  localparam logic [10:0] MV_1200 = 11'h4B0;
  localparam logic [10:0] MV_1400 = 11'h578;

  // De-emphasis codes and depths in tenths of a dB
  localparam logic [7:0] EMPH_0DB = 8'h01;
  localparam logic [7:0] EMPH_3P5DB = 8'h03;
  localparam logic [7:0] EMPH_6DB = 8'h05;
  localparam logic [7:0] EMPH_6DB_ENH = 8'h88;
  localparam logic [7:0] EMPH_9DB = 8'h90;
  localparam logic [7:0] EMPH_12DB = 8'hA0;
  localparam logic [7:0] EMPH_RESERVED = 8'hC0;
  localparam logic [6:0] TENTHS_0 = 7'h00;
  localparam logic [6:0] TENTHS_35 = 7'h23;
  localparam logic [6:0] TENTHS_60 = 7'h3C;
  localparam logic [6:0] TENTHS_90 = 7'h5A;
  localparam logic [6:0] TENTHS_120 = 7'h78;

  // Idle thresholds in mV, indexed by the two-bit code
  localparam logic [3:0][7:0] DEASSERT_MV = {8'hBE, 8'hAA, 8'h96, 8'h6E};
  localparam logic [3:0][7:0] ASSERT_MV = {8'h96, 8'h82, 8'h6E, 8'h46};

  // Management bus slave states
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001, ST_ADDR = 9'h002, ST_ACK_ADDR = 9'h004, ST_REG = 9'h008, ST_ACK_REG = 9'h010,
    ST_WDATA = 9'h020, ST_ACK_WR = 9'h040, ST_RDATA = 9'h080, ST_ACK_RD = 9'h100
  } smb_state_e;

  typedef struct packed {
    smb_state_e st;
    logic sclQ;
    logic sdaQ;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rw;
    logic nak;
    logic sdaOe;
    logic [NUM_REGS-1:0][7:0] bank;
  } cfg_state_s;

  typedef struct packed {
    logic outputMute;
    logic sigDetectEnable;
    logic rate5g;
    logic autoRate;
  } lane_mode_s;

  typedef struct packed {
    logic eqEnable;
    logic [1:0] gainStage;
    logic [2:0] boostLevel;
    logic eqActive;
    logic [4:0] eqLevel;
    logic eqStrapCode;
    logic [10:0] swingMv;
    logic swingValid;
    logic emphEnhanced;
    logic [6:0] emphLevel;
    logic [6:0] emphTenthDb;
    logic emphValid;
    logic emphReserved;
    logic [7:0] deassertMv;
    logic [7:0] assertMv;
  } lane_level_s;

endpackage : lane_cfg_pkg

// File: core/lane_mode_select.sv
// Purpose: Chooses idle muting and data rate from manual bits or automatic detectors
// Assumes: Detector inputs come from the analog lane and are synchronous
// Notes: Purely combinational from the stored register byte and the two detector inputs
`timescale 1ns/1ns
module lane_mode_select import lane_cfg_pkg::*; (
  input wire logic [7:0] idleRateReg,
  input wire logic signalDetect,
  input wire logic autoRateIs5g,
  output lane_mode_s mode
);

  // Idle and rate source selection
  always_comb begin
    mode.autoRate = idleRateReg[RATE_AUTO_BIT];
    if (idleRateReg[IDLE_AUTO_BIT]) begin
      mode.outputMute = ~signalDetect;
      mode.sigDetectEnable = 1'b1;
    end else begin
      mode.outputMute = ~idleRateReg[IDLE_MAN_BIT];
      mode.sigDetectEnable = 1'b0;
    end
    if (idleRateReg[RATE_AUTO_BIT]) begin
      mode.rate5g = autoRateIs5g;
    end else begin
      mode.rate5g = idleRateReg[RATE_MAN_BIT];
    end
  end

endmodule : lane_mode_select

// File: core/lane_level_decode.sv
// Purpose: Decodes equalizer, swing, de-emphasis and threshold bytes into lane levels
// Assumes: Bytes come straight from the configuration bank
// Notes: Undefined codes clear the matching valid flag
`timescale 1ns/1ns
module lane_level_decode import lane_cfg_pkg::*; (
  input wire logic [7:0] boostReg,
  input wire logic [7:0] swingReg,
  input wire logic [7:0] emphReg,
  input wire logic [7:0] threshReg,
  output lane_level_s level
);

  // Field split and table lookups
  always_comb begin
    level.eqEnable = boostReg[EQ_EN_BIT];
    level.gainStage = boostReg[GAIN_HI:GAIN_LO];
    level.boostLevel = boostReg[BOOST_HI:BOOST_LO];
    level.eqActive = (level.gainStage != 2'h0);
    level.eqLevel = level.eqActive ? 5'({level.gainStage - 2'h1, level.boostLevel}) : 5'h00;
    level.eqStrapCode = 1'b0;
    for (int i = 0; i < EQ_STRAP_CODES; i++) begin
      if (boostReg[5:0] == EQ_STRAP_TABLE[i]) level.eqStrapCode = 1'b1;
    end
    level.swingValid = 1'b1;
    case (swingReg[SWING_HI:0])
      SWING_600: level.swingMv = MV_600;
      SWING_800: level.swingMv = MV_800;
      SWING_1000: level.swingMv = MV_1000;
      SWING_1200: level.swingMv = MV_1200;
      SWING_1400: level.swingMv = MV_1400;
      default: begin
        level.swingMv = 11'h000;
        level.swingValid = 1'b0;
      end
    endcase
    level.emphEnhanced = emphReg[EMPH_TYPE_BIT];
    level.emphLevel = emphReg[EMPH_LVL_HI:0];
    level.emphReserved = (emphReg == EMPH_RESERVED);
    level.emphValid = 1'b1;
    case (emphReg)
      EMPH_0DB: level.emphTenthDb = TENTHS_0;
      EMPH_3P5DB: level.emphTenthDb = TENTHS_35;
      EMPH_6DB, EMPH_6DB_ENH: level.emphTenthDb = TENTHS_60;
      EMPH_9DB: level.emphTenthDb = TENTHS_90;
      EMPH_12DB: level.emphTenthDb = TENTHS_120;
      default: begin
        level.emphTenthDb = TENTHS_0;
        level.emphValid = 1'b0;
      end
    endcase
    level.deassertMv = DEASSERT_MV[threshReg[DEASSERT_HI:DEASSERT_LO]];
    level.assertMv = ASSERT_MV[threshReg[ASSERT_HI:ASSERT_LO]];
  end

endmodule : lane_level_decode

// File: core/lane_b2_config_registers.sv
// Purpose: Lane two B-path configuration bank behind the serial management bus
// Assumes: Management clock and data pins are synchronous to clock
// Notes: Byte writes take effect at the acknowledge of each data byte
//
// Contract
// - Idle-auto clear: mute follows manual bit
// - Idle-auto set: mute follows idle detection
// - Manual bit zero mutes, one keeps output on
// - Rate-auto clear: manual bit picks rate
// - Rate-auto set: detector picks rate
// - Equalizer byte splits enable, stage, boost
// - Twenty-four levels: three stages, eight boosts
// - Equalizer byte resets to bypass code
// - Nine strap choices map to fixed codes
// - Swing codes decode to five voltage levels
// - Top emphasis bit selects emphasis type
// - Six emphasis codes decode to five depths
// - Threshold byte holds de-assert and assert fields
// - Threshold codes map to voltage pairs
`timescale 1ns/1ns
module lane_b2_config_registers import lane_cfg_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h58 // Arbitrary default bus address
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic smbClkIn,
  input wire logic smbDataIn,
  output logic smbDataOut,
  output logic smbDataOe,
  input wire logic signalDetect,
  input wire logic autoRateIs5g,
  output lane_mode_s laneMode,
  output lane_level_s laneLevel,
  output logic [7:0] idleRateByte,
  output logic [7:0] boostByte,
  output logic [7:0] swingByte,
  output logic [7:0] emphByte,
  output logic [7:0] threshByte
);

  cfg_state_s state_r;
  cfg_state_s state_nxt;
  logic rstMeta_r;
  logic rstSync_r;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [7:0] readByte;

  // Offset maps into the bank
  function automatic logic regMapped(input logic [7:0] ofs);
    logic [7:0] idx;
    idx = 8'(ofs - BANK_BASE);
    regMapped = (ofs >= BANK_BASE) && (idx < 8'(NUM_REGS));
  endfunction : regMapped

  // Bank index of a mapped offset
  function automatic logic [2:0] regIndex(input logic [7:0] ofs);
    logic [7:0] idx;
    idx = 8'(ofs - BANK_BASE);
    regIndex = idx[2:0];
  endfunction : regIndex

  // Read value, zero for unmapped offsets
  function automatic logic [7:0] regRead(input logic [NUM_REGS-1:0][7:0] bank, input logic [7:0] ofs);
    regRead = 8'h00;
    if (regMapped(ofs)) regRead = bank[regIndex(ofs)];
  endfunction : regRead

  // Reset release through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // Bus edge and condition detection
  assign sclRise = smbClkIn && !state_r.sclQ;
  assign sclFall = !smbClkIn && state_r.sclQ;
  assign startSeen = smbClkIn && state_r.sclQ && state_r.sdaQ && !smbDataIn;
  assign stopSeen = smbClkIn && state_r.sclQ && !state_r.sdaQ && smbDataIn;
  assign readByte = regRead(state_r.bank, state_r.ptr);

  // Slave sequencing and register writes
  always_comb begin
    state_nxt = state_r;
    state_nxt.sclQ = smbClkIn;
    state_nxt.sdaQ = smbDataIn;
    if (startSeen) begin
      state_nxt.st = ST_ADDR;
      state_nxt.bitCnt = 4'h0;
      state_nxt.sdaOe = 1'b0;
    end else if (stopSeen) begin
      state_nxt.st = ST_IDLE;
      state_nxt.sdaOe = 1'b0;
    end else begin
      case (state_r.st)
        ST_IDLE: begin
          state_nxt.sdaOe = 1'b0;
        end
        ST_ADDR: begin
          if (sclRise) begin
            state_nxt.shift = {state_r.shift[6:0], smbDataIn};
            state_nxt.bitCnt = 4'(state_r.bitCnt + 4'h1);
          end else if (sclFall && state_r.bitCnt == 4'h8) begin
            state_nxt.bitCnt = 4'h0;
            if (state_r.shift[7:1] == DEV_ADDR) begin
              state_nxt.rw = state_r.shift[0];
              state_nxt.sdaOe = 1'b1; // Acknowledge own address
              state_nxt.st = ST_ACK_ADDR;
            end else begin
              state_nxt.st = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (sclFall) begin
            if (state_r.rw) begin
              state_nxt.shift = readByte;
              state_nxt.sdaOe = ~readByte[7];
              state_nxt.st = ST_RDATA;
            end else begin
              state_nxt.sdaOe = 1'b0;
              state_nxt.st = ST_REG;
            end
          end
        end
        ST_REG: begin
          if (sclRise) begin
            state_nxt.shift = {state_r.shift[6:0], smbDataIn};
            state_nxt.bitCnt = 4'(state_r.bitCnt + 4'h1);
          end else if (sclFall && state_r.bitCnt == 4'h8) begin
            state_nxt.bitCnt = 4'h0;
            state_nxt.ptr = state_r.shift;
            state_nxt.sdaOe = 1'b1;
            state_nxt.st = ST_ACK_REG;
          end
        end
        ST_ACK_REG, ST_ACK_WR: begin
          if (sclFall) begin
            state_nxt.sdaOe = 1'b0;
            state_nxt.st = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (sclRise) begin
            state_nxt.shift = {state_r.shift[6:0], smbDataIn};
            state_nxt.bitCnt = 4'(state_r.bitCnt + 4'h1);
          end else if (sclFall && state_r.bitCnt == 4'h8) begin
            state_nxt.bitCnt = 4'h0;
            if (regMapped(state_r.ptr)) begin
              state_nxt.bank[regIndex(state_r.ptr)] = state_r.shift;
            end
            state_nxt.ptr = 8'(state_r.ptr + 8'h01);
            state_nxt.sdaOe = 1'b1;
            state_nxt.st = ST_ACK_WR;
          end
        end
        ST_RDATA: begin
          if (sclRise) begin
            state_nxt.bitCnt = 4'(state_r.bitCnt + 4'h1);
          end else if (sclFall) begin
            if (state_r.bitCnt == 4'h8) begin
              state_nxt.bitCnt = 4'h0;
              state_nxt.sdaOe = 1'b0; // Release for master acknowledge
              state_nxt.st = ST_ACK_RD;
            end else begin
              state_nxt.sdaOe = ~state_r.shift[3'(4'h7 - state_r.bitCnt)];
            end
          end
        end
        ST_ACK_RD: begin
          if (sclRise) begin
            state_nxt.nak = smbDataIn;
            state_nxt.ptr = 8'(state_r.ptr + 8'h01);
          end else if (sclFall) begin
            if (state_r.nak) begin
              state_nxt.st = ST_IDLE;
            end else begin
              state_nxt.shift = readByte;
              state_nxt.sdaOe = ~readByte[7];
              state_nxt.st = ST_RDATA;
            end
          end
        end
        default: begin
          state_nxt.st = ST_IDLE;
          state_nxt.sdaOe = 1'b0;
        end
      endcase
    end
  end

  // State register with documented reset bytes
  always_ff @(posedge clock or negedge rstSync_r) begin
    if (!rstSync_r) begin
      state_r.st <= ST_IDLE;
      state_r.sclQ <= 1'b1;
      state_r.sdaQ <= 1'b1;
      state_r.bitCnt <= 4'h0;
      state_r.shift <= 8'h00;
      state_r.ptr <= 8'h00;
      state_r.rw <= 1'b0;
      state_r.nak <= 1'b0;
      state_r.sdaOe <= 1'b0;
      state_r.bank <= {THRESH_RST, EMPH_RST, SWING_RST, BOOST_RST, IDLE_RATE_RST};
    end else begin
      state_r <= state_nxt;
    end
  end

  // Open-drain data pin: drives low only
  assign smbDataOut = 1'b0;
  assign smbDataOe = state_r.sdaOe;

  // Stored bytes to the lane
  assign idleRateByte = state_r.bank[0];
  assign boostByte = state_r.bank[1];
  assign swingByte = state_r.bank[2];
  assign emphByte = state_r.bank[3];
  assign threshByte = state_r.bank[4];

  // Idle and rate source selection
  lane_mode_select lane_mode_select_i (
    .idleRateReg(state_r.bank[0]),
    .signalDetect(signalDetect),
    .autoRateIs5g(autoRateIs5g),
    .mode(laneMode)
  );

  // Level decoding for the analog settings
  lane_level_decode lane_level_decode_i (
    .boostReg(state_r.bank[1]),
    .swingReg(state_r.bank[2]),
    .emphReg(state_r.bank[3]),
    .threshReg(state_r.bank[4]),
    .level(laneLevel)
  );

endmodule : lane_b2_config_registers

// File: tb/lane_b2_config_registers_properties.sv
// Purpose: Port assertions for the lane two B-path configuration bank
// Assumes: Management clock low phase outlasts the answer delay
// Notes: Bound to every instance of the bank
`timescale 1ns/1ns
module lane_b2_config_registers_properties import lane_cfg_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic smbClkIn,
  input wire logic smbDataOe,
  input wire logic signalDetect,
  input wire logic autoRateIs5g,
  input wire lane_mode_s laneMode,
  input wire lane_level_s laneLevel,
  input wire logic [7:0] idleRateByte,
  input wire logic [7:0] boostByte,
  input wire logic [7:0] swingByte,
  input wire logic [7:0] emphByte,
  input wire logic [7:0] threshByte
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Acknowledge start and any stored byte moving
  sequence ackRise;
    $rose(smbDataOe);
  endsequence
  sequence byteMoves;
    !$stable({idleRateByte, boostByte, swingByte, emphByte, threshByte});
  endsequence
  mute_manual_a: assert property (!idleRateByte[5] |-> laneMode.outputMute == !idleRateByte[4])
    else $error("manual mute differs from stored bit");
  mute_auto_a: assert property (idleRateByte[5] |-> laneMode.outputMute == !signalDetect)
    else $error("auto mute does not follow detector");
  rate_manual_a: assert property (!idleRateByte[1] |-> laneMode.rate5g == idleRateByte[0])
    else $error("manual rate differs from stored bit");
  rate_auto_a: assert property (idleRateByte[1] |-> laneMode.rate5g == autoRateIs5g)
    else $error("auto rate does not follow detector");
  eq_split_a: assert property ({laneLevel.eqEnable, laneLevel.gainStage, laneLevel.boostLevel} == boostByte[5:0])
    else $error("equalizer fields split wrongly");
  eq_level_a: assert property (laneLevel.gainStage != 2'h0 |-> laneLevel.eqActive
    && laneLevel.eqLevel == 5'((laneLevel.gainStage - 2'h1) * 5'h08 + laneLevel.boostLevel))
    else $error("equalizer level number wrong");
  swing_top_a: assert property (swingByte[6:0] == SWING_1400 |-> laneLevel.swingValid && laneLevel.swingMv == MV_1400)
    else $error("top swing code decoded wrongly");
  emph_type_a: assert property (laneLevel.emphEnhanced == emphByte[7])
    else $error("emphasis type bit not followed");
  thresh_pair_a: assert property (laneLevel.deassertMv == DEASSERT_MV[threshByte[3:2]]
    && laneLevel.assertMv == ASSERT_MV[threshByte[1:0]])
    else $error("idle threshold pair wrong");
  commit_at_ack_a: assert property (byteMoves |-> ackRise)
    else $error("stored byte changed outside a data acknowledge");
  ack_low_a: assert property ($changed(smbDataOe) |-> !smbClkIn)
    else $error("data pull changed while bus clock high");
endmodule : lane_b2_config_registers_properties
bind lane_b2_config_registers lane_b2_config_registers_properties lane_b2_config_registers_properties_i (
  .clock(clock), .rst_n(rst_n), .smbClkIn(smbClkIn), .smbDataOe(smbDataOe), .signalDetect(signalDetect),
  .autoRateIs5g(autoRateIs5g), .laneMode(laneMode), .laneLevel(laneLevel), .idleRateByte(idleRateByte),
  .boostByte(boostByte), .swingByte(swingByte), .emphByte(emphByte), .threshByte(threshByte));

// File: tb/smb_host.sv
// Purpose: Management bus host that configures the lane bank
// Assumes: Both bus lines pulled up; the device only pulls data low
// Notes: Raise ph to model a slow host
`timescale 1ns/1ns
module smb_host (
  input wire logic clock,
  input wire logic smbDataOe,
  output logic scl,
  output logic sdaLine,
  output logic [7:0] rdData,
  output logic rdValid
);
  logic sdaDrv;
  int ph;
  // Wired-AND of host and device on the data line
  assign sdaLine = sdaDrv & !smbDataOe;
  initial begin
    scl = 1'b1; sdaDrv = 1'b1; rdData = 8'h00; rdValid = 1'b0; ph = 3;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // One clock pulse; data moves only while the clock is low
  task automatic bitCycle(input logic b, output logic r);
    sdaDrv = b; tick(ph); scl = 1'b1; tick(ph); r = sdaLine; scl = 1'b0; tick(ph);
  endtask : bitCycle
  task automatic startCond;
    sdaDrv = 1'b1; tick(ph); scl = 1'b1; tick(ph); sdaDrv = 1'b0; tick(ph); scl = 1'b0; tick(ph);
  endtask : startCond
  task automatic stopCond;
    sdaDrv = 1'b0; tick(ph); scl = 1'b1; tick(ph); sdaDrv = 1'b1; tick(ph);
  endtask : stopCond
  task automatic sendByte(input logic [7:0] b, output logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bitCycle(b[i], r);
    bitCycle(1'b1, r);
    ok = !r;
  endtask : sendByte
  task automatic writeBytes(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d[$], output logic ok);
    logic k;
    startCond();
    sendByte({a, 1'b0}, ok);
    if (ok) begin
      sendByte(ofs, k); ok &= k;
      foreach (d[i]) begin sendByte(d[i], k); ok &= k; end
    end
    stopCond();
  endtask : writeBytes
  // Last byte is refused by the host to end the read
  task automatic readBytes(input logic [6:0] a, input logic [7:0] ofs, input int n, output logic ok);
    logic k;
    logic r;
    logic [7:0] d;
    startCond();
    sendByte({a, 1'b0}, ok); sendByte(ofs, k); ok &= k;
    startCond();
    sendByte({a, 1'b1}, k); ok &= k;
    for (int j = 0; j < n; j++) begin
      for (int i = 7; i >= 0; i--) begin bitCycle(1'b1, r); d[i] = r; end
      rdData = d; rdValid = 1'b1; tick(1); rdValid = 1'b0;
      bitCycle(j == n - 1, r);
    end
    stopCond();
  endtask : readBytes
endmodule : smb_host

// File: tb/lane_b2_config_registers_bench.sv
// Purpose: Self-checking bench for the lane two B-path configuration bank
// Assumes: Host model speaks the management bus with pull-ups
// Notes: Read bytes are matched against a queue of expected values
`timescale 1ns/1ns
module lane_b2_config_registers_bench import lane_cfg_pkg::*;;
  localparam logic [6:0] BUS_ADDR = 7'h2B; // Arbitrary bus address
  localparam logic [7:0] STRAP[9] = '{8'h20, 8'h2A, 8'h30, 8'h32, 8'h39, 8'h35, 8'h37, 8'h3B, 8'h3D};
  localparam logic [7:0] SWC[5] = '{8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F};
  localparam logic [15:0] SWMV[5] = '{16'h258, 16'h320, 16'h3E8, 16'h4B0, 16'h578};
  localparam logic [7:0] EMC[6] = '{8'h01, 8'h03, 8'h05, 8'h88, 8'h90, 8'hA0};
  localparam logic [15:0] EMT[6] = '{16'h0, 16'h23, 16'h3C, 16'h3C, 16'h5A, 16'h78};
  localparam logic [15:0] DAS[4] = '{16'h6E, 16'h96, 16'hAA, 16'hBE};
  localparam logic [15:0] AST[4] = '{16'h46, 16'h6E, 16'h82, 16'h96};
  localparam logic [7:0] MASK[5] = '{8'h33, 8'h3F, 8'h7F, 8'hBF, 8'h0F};
  logic clock, rst_n, signalDetect, autoRateIs5g, smbClkIn, smbDataIn, smbDataOe, rdValid, ok;
  logic [7:0] rdData, v;
  logic [7:0] q[$];
  logic [7:0] expQ[$];
  lane_mode_s laneMode;
  lane_level_s laneLevel;
  int errors = 0;
  int totalChecks = 0;
  lane_b2_config_registers #(.DEV_ADDR(BUS_ADDR)) lane_b2_config_registers_i (.clock(clock), .rst_n(rst_n),
    .smbClkIn(smbClkIn), .smbDataIn(smbDataIn), .smbDataOut(), .smbDataOe(smbDataOe),
    .signalDetect(signalDetect), .autoRateIs5g(autoRateIs5g), .laneMode(laneMode), .laneLevel(laneLevel),
    .idleRateByte(), .boostByte(), .swingByte(), .emphByte(), .threshByte());
  smb_host smb_host_i (.clock(clock), .smbDataOe(smbDataOe), .scl(smbClkIn), .sdaLine(smbDataIn),
    .rdData(rdData), .rdValid(rdValid));
  // Clock at 8 ns
  initial begin
    clock = 1'b0;
    forever #4 clock = !clock;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
    logic k;
    logic [7:0] d[$];
    d = {val};
    smb_host_i.writeBytes(BUS_ADDR, ofs, d, k);
    cmp(k, 1'b1, "write ack");
  endtask : wr
  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp[$]);
    logic k;
    expQ = {expQ, exp};
    smb_host_i.readBytes(BUS_ADDR, ofs, exp.size(), k);
    cmp(k, 1'b1, "read ack");
  endtask : rd
  task testDone;
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : testDone
  // Oldest expected read byte against each byte the host receives
  always @(posedge clock) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) cmp(rdData, 16'hFFFF, "unexpected read");
      else cmp(rdData, expQ.pop_front(), "read byte");
    end
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    testDone();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0; signalDetect = 1'b0; autoRateIs5g = 1'b0;
    void'($urandom(23538));
    repeat (16) @(posedge clock);
    #1 rst_n = 1'b1;
    smb_host_i.tick(8);
    q = {8'h00, 8'h20, 8'h03, 8'h03, 8'h00, 8'h00};
    rd(IDLE_RATE_OFS, q);
    cmp(laneLevel.swingMv, SWMV[0], "reset swing");
    cmp(laneLevel.emphTenthDb, EMT[1], "reset emphasis");
    // Every strap code, written and read back
    for (int i = 0; i < 9; i++) begin
      wr(BOOST_OFS, STRAP[i]);
      cmp({laneLevel.eqEnable, laneLevel.gainStage, laneLevel.boostLevel}, STRAP[i][5:0], "eq fields");
      cmp(laneLevel.eqStrapCode, 1'b1, "strap flag");
      if (i > 0) cmp(laneLevel.eqLevel, (STRAP[i][4:3] - 1) * 8 + STRAP[i][2:0], "eq level");
      cmp(laneLevel.eqActive, i > 0, "eq active");
      q = {STRAP[i]};
      rd(BOOST_OFS, q);
    end
    // A code outside the strap set must not be flagged
    wr(BOOST_OFS, 8'h21);
    cmp(laneLevel.eqStrapCode, 1'b0, "non-strap code");
    // All idle and rate selections with random detector levels
    for (int i = 0; i < 16; i++) begin
      signalDetect = 1'($urandom);
      autoRateIs5g = 1'($urandom);
      wr(IDLE_RATE_OFS, {2'b00, i[3], i[2], 2'b00, i[1], i[0]});
      cmp(laneMode.outputMute, i[3] ? !signalDetect : !i[2], "mute");
      cmp(laneMode.rate5g, i[1] ? autoRateIs5g : i[0], "rate");
      cmp(laneMode.sigDetectEnable, i[3], "detect enable");
      cmp(laneMode.autoRate, i[1], "auto rate");
    end
    for (int i = 0; i < 5; i++) begin
      wr(SWING_OFS, SWC[i]);
      cmp(laneLevel.swingMv, SWMV[i], "swing");
      cmp(laneLevel.swingValid, 1'b1, "swing valid");
    end
    // Undefined swing code is flagged invalid
    wr(SWING_OFS, 8'h01);
    cmp(laneLevel.swingValid, 1'b0, "swing undefined");
    for (int i = 0; i < 6; i++) begin
      wr(EMPH_OFS, EMC[i]);
      cmp(laneLevel.emphTenthDb, EMT[i], "emphasis depth");
      cmp(laneLevel.emphEnhanced, EMC[i][7], "emphasis type");
      cmp(laneLevel.emphLevel, EMC[i][6:0], "emphasis level");
      cmp(laneLevel.emphValid, 1'b1, "emphasis valid");
      cmp(laneLevel.emphReserved, 1'b0, "emphasis reserved");
    end
    for (int i = 0; i < 16; i++) begin
      wr(THRESH_OFS, 8'(i));
      cmp(laneLevel.deassertMv, DAS[i / 4], "deassert");
      cmp(laneLevel.assertMv, AST[i % 4], "assert");
    end
    // Slow host: burst write, foreign address refused, unmapped place dropped
    smb_host_i.ph = 9;
    q = {};
    for (int i = 0; i < 5; i++) q.push_back(8'($urandom) & MASK[i]);
    smb_host_i.writeBytes(BUS_ADDR, IDLE_RATE_OFS, q, ok);
    cmp(ok, 1'b1, "burst ack");
    v = 8'($urandom);
    smb_host_i.writeBytes(BUS_ADDR ^ 7'h01, IDLE_RATE_OFS, '{v}, ok);
    cmp(ok, 1'b0, "foreign address");
    wr(8'h21, v);
    q.push_back(8'h00);
    rd(IDLE_RATE_OFS, q);
    smb_host_i.tick(4);
    cmp(expQ.size(), 16'h0, "reads outstanding");
    testDone();
  end
endmodule : lane_b2_config_registers_bench
